// ==== logic/uedb_block.sv ====
// Endpoint descriptor table with firmware port and buffer manager lookup and update engine.
`timescale 1ns/1ps
`include "uedb_params.svh"
module uedb_block (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic [6:0] MCU_ADDR,
   input wire logic MCU_WE,
   input wire logic MCU_RE,
   input wire logic [7:0] MCU_WDATA,
   output logic [7:0] MCU_RDATA,
   output logic MCU_RVALID,
   input wire logic UBM_REQ,
   input wire logic [2:0] UBM_EP,
   output logic UBM_READY,
   output logic UBM_RESP_VALID,
   output logic [1:0] UBM_RESP,
   output logic [10:0] UBM_START_ADDR,
   output logic [6:0] UBM_MAX_SIZE,
   output logic UBM_USE_Y,
   input wire logic UBM_DONE,
   input wire logic [2:0] UBM_DONE_EP,
   input wire logic [6:0] UBM_DONE_LEN,
   output logic EP_IRQ
);
   localparam uedb_pkg::uedb_core_t CORE_RESET = '{state: uedb_pkg::UEDB_IDLE, ready: 1'b1,
      resp: uedb_pkg::UEDB_RESP_ACCEPT, default: '0};

   uedb_pkg::uedb_core_t q;
   uedb_pkg::uedb_core_t next_q;
   logic wr_en;
   logic [6:0] wr_idx;
   logic [7:0] wr_data;
   logic [7:0] mcu_byte;
   logic [63:0] desc;
   logic mcu_wr;
   logic [7:0] cfg;
   logic [7:0] cnt_sel;
   logic sel_y;

   function automatic logic [7:0] desc_byte(input logic [63:0] d, input logic [2:0] ofs);
      desc_byte = d[{ofs, 3'h0} +: 8];
   endfunction

   uedb_desc_ram #(.ADDR_W(7)) u_ram (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .we(wr_en),
      .widx(wr_idx),
      .wdata(wr_data),
      .ridx(MCU_ADDR),
      .rdata(mcu_byte),
      .desc_idx({`UEDB_DIR_OUT, q.ep}),
      .desc(desc)
   );

   // ----------------------------------------
   // Descriptor decode
   // ----------------------------------------
   assign cfg = desc_byte(desc, `UEDB_OFS_CFG);
   assign sel_y = cfg[`UEDB_CFG_DOUBLE_BUFFER_ENABLE] & cfg[`UEDB_CFG_TOGGLE];
   assign cnt_sel = desc_byte(desc, sel_y ? `UEDB_OFS_YCNT : `UEDB_OFS_XCNT);
   // Endpoint 0 sits in dedicated registers elsewhere, so its slots here are never written.
   assign mcu_wr = MCU_WE && (MCU_ADDR[5:3] != `UEDB_EP_NONE);

   // ----------------------------------------
   // Engine
   // ----------------------------------------
   always_comb begin
      next_q = q;
      next_q.resp_valid = 1'b0;
      next_q.irq = 1'b0;
      next_q.rvalid = MCU_RE;
      next_q.rdata = (MCU_ADDR[5:3] == `UEDB_EP_NONE) ? 8'h00 : mcu_byte;
      wr_en = mcu_wr;
      wr_idx = MCU_ADDR;
      wr_data = MCU_WDATA;
      // Firmware always wins the single write port; the engine simply waits a cycle.
      if (mcu_wr) begin
         if (MCU_ADDR[2:0] == `UEDB_OFS_CFG) begin
            wr_data = MCU_WDATA & `UEDB_CFG_WMASK;
         end else if (MCU_ADDR[2:0] == `UEDB_OFS_SIZE) begin
            wr_data = MCU_WDATA & `UEDB_SIZE_WMASK;
         end
      end
      unique case (q.state)
         uedb_pkg::UEDB_IDLE: begin
            if (UBM_DONE && UBM_DONE_EP != `UEDB_EP_NONE) begin
               next_q.ep = UBM_DONE_EP;
               next_q.len = UBM_DONE_LEN;
               next_q.state = uedb_pkg::UEDB_DONE_CNT;
               next_q.ready = 1'b0;
            end else if (UBM_REQ && !UBM_DONE) begin
               next_q.ep = UBM_EP;
               next_q.state = uedb_pkg::UEDB_ANSWER;
               next_q.ready = 1'b0;
            end
         end
         uedb_pkg::UEDB_ANSWER: begin
            next_q.resp_valid = 1'b1;
            next_q.use_y = sel_y;
            next_q.start_addr = {desc_byte(desc, sel_y ? `UEDB_OFS_YBASE : `UEDB_OFS_XBASE),
               `UEDB_PAD_BITS};
            next_q.max_size = 7'(desc_byte(desc, `UEDB_OFS_SIZE) & `UEDB_SIZE_WMASK);
            if (q.ep == `UEDB_EP_NONE || !cfg[`UEDB_CFG_MGR]) begin
               next_q.resp = uedb_pkg::UEDB_RESP_OFF;
            end else if (cfg[`UEDB_CFG_STALL]) begin
               next_q.resp = uedb_pkg::UEDB_RESP_STALL;
            end else if (cnt_sel[`UEDB_CNT_NAK]) begin
               next_q.resp = uedb_pkg::UEDB_RESP_NAK;
            end else begin
               next_q.resp = uedb_pkg::UEDB_RESP_ACCEPT;
            end
            next_q.state = uedb_pkg::UEDB_IDLE;
            next_q.ready = 1'b1;
         end
         uedb_pkg::UEDB_DONE_CNT: begin
            if (!mcu_wr) begin
               wr_en = 1'b1;
               wr_idx = {`UEDB_DIR_OUT, q.ep, sel_y ? `UEDB_OFS_YCNT : `UEDB_OFS_XCNT};
               wr_data = {1'b1, q.len};
               next_q.state = uedb_pkg::UEDB_DONE_CFG;
            end
         end
         uedb_pkg::UEDB_DONE_CFG: begin
            if (!mcu_wr) begin
               wr_en = 1'b1;
               wr_idx = {`UEDB_DIR_OUT, q.ep, `UEDB_OFS_CFG};
               wr_data = cfg ^ (8'h01 << `UEDB_CFG_TOGGLE);
               next_q.irq = cfg[`UEDB_CFG_IRQ];
               next_q.state = uedb_pkg::UEDB_IDLE;
               next_q.ready = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         q <= CORE_RESET;
      end else begin
         q <= next_q;
      end
   end

   assign MCU_RDATA = q.rdata;
   assign MCU_RVALID = q.rvalid;
   assign UBM_READY = q.ready;
   assign UBM_RESP_VALID = q.resp_valid;
   assign UBM_RESP = q.resp;
   assign UBM_START_ADDR = q.start_addr;
   assign UBM_MAX_SIZE = q.max_size;
   assign UBM_USE_Y = q.use_y;
   assign EP_IRQ = q.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   a_resp_timing: assert property (UBM_READY && UBM_REQ && !UBM_DONE |-> ##2 UBM_RESP_VALID)
      else $error("Lookup answer not two cycles after request.");
   a_mgr_off: assert property (q.state == uedb_pkg::UEDB_ANSWER && !cfg[`UEDB_CFG_MGR]
      |=> UBM_RESP == uedb_pkg::UEDB_RESP_OFF)
      else $error("Disabled endpoint was serviced.");
   a_stall_answer: assert property (q.state == uedb_pkg::UEDB_ANSWER && cfg[`UEDB_CFG_MGR]
      && cfg[`UEDB_CFG_STALL] && q.ep != `UEDB_EP_NONE |=> UBM_RESP == uedb_pkg::UEDB_RESP_STALL)
      else $error("Stall flag did not give a stall answer.");
   a_nak_answer: assert property (q.state == uedb_pkg::UEDB_ANSWER && cfg[`UEDB_CFG_MGR]
      && !cfg[`UEDB_CFG_STALL] && cnt_sel[`UEDB_CNT_NAK] && q.ep != `UEDB_EP_NONE
      |=> UBM_RESP == uedb_pkg::UEDB_RESP_NAK)
      else $error("Full buffer did not give a NAK answer.");
   a_start_addr: assert property (q.state == uedb_pkg::UEDB_ANSWER && !sel_y
      |=> UBM_START_ADDR == {$past(desc[15:8]), 3'h0})
      else $error("Start address not formed from the X base.");
   a_single_buf: assert property (q.state == uedb_pkg::UEDB_ANSWER && !cfg[`UEDB_CFG_DOUBLE_BUFFER_ENABLE]
      |=> !UBM_USE_Y)
      else $error("Y buffer chosen with double buffering off.");
   a_irq_gate: assert property (q.state == uedb_pkg::UEDB_DONE_CFG && !mcu_wr
      |=> EP_IRQ == $past(cfg[`UEDB_CFG_IRQ]))
      else $error("Completion pulse disagrees with its enable.");
   a_toggle_flip: assert property (q.state == uedb_pkg::UEDB_DONE_CFG && !mcu_wr
      |-> wr_en && wr_data[`UEDB_CFG_TOGGLE] != cfg[`UEDB_CFG_TOGGLE])
      else $error("Toggle not advanced on completion.");
   a_count_nak: assert property (q.state == uedb_pkg::UEDB_DONE_CNT && !mcu_wr
      |-> wr_en && wr_data == {1'b1, q.len})
      else $error("Count update lacks length or NAK flag.");
   a_base_kept: assert property (wr_en && !mcu_wr
      |-> wr_idx[2:0] != `UEDB_OFS_XBASE && wr_idx[2:0] != `UEDB_OFS_YBASE)
      else $error("Engine wrote a base address.");
   a_cfg_reserved: assert property (wr_en && wr_idx[2:0] == `UEDB_OFS_CFG |-> wr_data[1:0] == 2'b00)
      else $error("Reserved config bits written as one.");

   a_rd_echo: assert property (MCU_RE |=> MCU_RVALID)
      else $error("Firmware read not answered.");
   a_ep0_zero: assert property (MCU_RE && MCU_ADDR[5:3] == `UEDB_EP_NONE |=> MCU_RDATA == 8'h00)
      else $error("Endpoint 0 slot read back nonzero.");
   a_done_busy: assert property (UBM_READY && UBM_DONE && UBM_DONE_EP != `UEDB_EP_NONE |=> !UBM_READY)
      else $error("Completion not taken.");

   c_accept: cover property (UBM_RESP_VALID && UBM_RESP == uedb_pkg::UEDB_RESP_ACCEPT);
   c_nak: cover property (UBM_RESP_VALID && UBM_RESP == uedb_pkg::UEDB_RESP_NAK);
   c_stall: cover property (UBM_RESP_VALID && UBM_RESP == uedb_pkg::UEDB_RESP_STALL);
   c_done_irq: cover property (EP_IRQ);
   c_clash: cover property (q.state == uedb_pkg::UEDB_DONE_CNT && mcu_wr);
endmodule

// ==== logic/uedb_desc_ram.sv ====
// Descriptor storage: byte write port, byte read port and a whole-descriptor read port.
`timescale 1ns/1ps
`include "uedb_params.svh"
module uedb_desc_ram #(
   parameter int ADDR_W = 7
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic we,
   input wire logic [ADDR_W-1:0] widx,
   input wire logic [7:0] wdata,
   input wire logic [ADDR_W-1:0] ridx,
   output logic [7:0] rdata,
   input wire logic [ADDR_W-4:0] desc_idx,
   output logic [63:0] desc
);
   localparam int DEPTH = 2 ** ADDR_W;
   logic [7:0] mem [DEPTH];

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   // Only the stall flags have a reset value; the rest of the table is left for firmware.
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < DEPTH / 8; i++) begin
            mem[i * 8][`UEDB_CFG_STALL] <= 1'b0;
         end
      end else if (we) begin
         mem[widx] <= wdata;
      end
   end

   assign rdata = mem[ridx];

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_desc
         assign desc[g*8 +: 8] = mem[{desc_idx, 3'(g)}];
      end
   endgenerate
endmodule

// ==== logic/uedb_params.svh ====
// Offsets, bit positions and masks of the endpoint descriptor block.
`ifndef UEDB_PARAMS_SVH
`define UEDB_PARAMS_SVH
`define UEDB_OFS_CFG 3'h0
`define UEDB_OFS_XBASE 3'h1
`define UEDB_OFS_XCNT 3'h2
`define UEDB_OFS_YBASE 3'h5
`define UEDB_OFS_YCNT 3'h6
`define UEDB_OFS_SIZE 3'h7
`define UEDB_CFG_IRQ 2
`define UEDB_CFG_STALL 3
`define UEDB_CFG_DOUBLE_BUFFER_ENABLE 4
`define UEDB_CFG_TOGGLE 5
`define UEDB_CFG_MGR 7
`define UEDB_CNT_NAK 7
`define UEDB_CFG_WMASK 8'hfc
`define UEDB_SIZE_WMASK 8'h7f
`define UEDB_PAD_BITS 3'h0
`define UEDB_EP_NONE 3'h0
`define UEDB_DIR_OUT 1'h0
`endif

// ==== logic/uedb_pkg.sv ====
// Types shared by the endpoint descriptor block.
package uedb_pkg;
   typedef enum logic [1:0] {
      UEDB_RESP_ACCEPT = 2'b00,
      UEDB_RESP_NAK = 2'b01,
      UEDB_RESP_STALL = 2'b10,
      UEDB_RESP_OFF = 2'b11
   } uedb_resp_t;
   typedef enum logic [1:0] {
      UEDB_IDLE = 2'b00,
      UEDB_ANSWER = 2'b01,
      UEDB_DONE_CNT = 2'b10,
      UEDB_DONE_CFG = 2'b11
   } uedb_state_t;
   typedef struct packed {
      uedb_state_t state;
      logic [2:0] ep;
      logic [6:0] len;
      logic ready;
      logic resp_valid;
      uedb_resp_t resp;
      logic [10:0] start_addr;
      logic [6:0] max_size;
      logic use_y;
      logic [7:0] rdata;
      logic rvalid;
      logic irq;
   } uedb_core_t;
endpackage

// ==== testbench/testbench.sv ====
// Self-checking bench for the endpoint descriptor block.
`timescale 1ns/1ps
`include "uedb_params.svh"
module testbench;
   logic clk, rst, we, re, rvalid, req, ready, resp_valid, usey, done, irq;
   logic [6:0] addr, maxs, dlen;
   logic [7:0] wdata, rdata;
   logic [2:0] ep, dep;
   logic [1:0] resp;
   logic [10:0] start;
   logic [7:0] m [128];
   int fail_count, n_tests;
   int cyc = 0;
   uedb_block dut (.CORE_CLK(clk), .SYS_RST(rst), .MCU_ADDR(addr), .MCU_WE(we), .MCU_RE(re), .MCU_WDATA(wdata),
      .MCU_RDATA(rdata), .MCU_RVALID(rvalid), .UBM_REQ(req), .UBM_EP(ep), .UBM_READY(ready),
      .UBM_RESP_VALID(resp_valid), .UBM_RESP(resp), .UBM_START_ADDR(start), .UBM_MAX_SIZE(maxs),
      .UBM_USE_Y(usey), .UBM_DONE(done), .UBM_DONE_EP(dep), .UBM_DONE_LEN(dlen), .EP_IRQ(irq));
   uedb_mgr_model mgr (.clk(clk), .ready(ready), .req(req), .ep(ep), .done(done), .done_ep(dep),
      .done_len(dlen));
   // ----------------------------------------
   // Tasks.
   // ----------------------------------------
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      we = 1'b1;
      addr = a;
      wdata = d;
      if (a[5:3] != 3'h0) begin
         m[a] = d & ((a[2:0] == `UEDB_OFS_CFG) ? `UEDB_CFG_WMASK :
            (a[2:0] == `UEDB_OFS_SIZE) ? `UEDB_SIZE_WMASK : 8'hff);
      end
      @(negedge clk);
      we = 1'b0;
      addr = ~a;
      wdata = ~d;
   endtask
   // Reads leave a gap cycle so one answer never hides behind the next.
   task automatic rd(input logic [6:0] a, input logic [7:0] msk);
      @(negedge clk);
      re = 1'b1;
      addr = a;
      @(negedge clk);
      re = 1'b0;
      addr = ~a;
      cmp(rvalid, 1'b1);
      cmp(rdata & msk, m[a] & msk);
   endtask
   task automatic look(input logic [2:0] e);
      logic [7:0] c;
      logic y;
      logic [1:0] r;
      c = m[{1'b0, e, 3'h0}];
      y = c[`UEDB_CFG_DOUBLE_BUFFER_ENABLE] & c[`UEDB_CFG_TOGGLE];
      if (e == 3'h0 || !c[`UEDB_CFG_MGR]) r = 2'h3;
      else if (c[`UEDB_CFG_STALL]) r = 2'h2;
      else if (m[{1'b0, e, (y ? `UEDB_OFS_YCNT : `UEDB_OFS_XCNT)}][`UEDB_CNT_NAK]) r = 2'h1;
      else r = 2'h0;
      mgr.xfer(1'b0, e, 7'h0);
      cmp(resp_valid, 1'b0);
      @(negedge clk);
      cmp(resp_valid, 1'b1);
      cmp(resp, r);
      if (r != 2'h3) begin
         cmp(usey, y);
         cmp(start, {m[{1'b0, e, (y ? `UEDB_OFS_YBASE : `UEDB_OFS_XBASE)}], 3'h0});
         cmp(maxs, m[{1'b0, e, `UEDB_OFS_SIZE}][6:0]);
      end
   endtask
   task automatic fin(input logic [2:0] e, input logic [6:0] n, input int lag);
      logic [7:0] c;
      logic y;
      c = m[{1'b0, e, 3'h0}];
      y = c[`UEDB_CFG_DOUBLE_BUFFER_ENABLE] & c[`UEDB_CFG_TOGGLE];
      mgr.xfer(1'b1, e, n);
      repeat (2 + lag) @(negedge clk);
      cmp(irq, c[`UEDB_CFG_IRQ]);
      cmp(ready, 1'b1);
      if (e != 3'h0) begin
         m[{1'b0, e, (y ? `UEDB_OFS_YCNT : `UEDB_OFS_XCNT)}] = {1'b1, n};
         m[{1'b0, e, 3'h0}][`UEDB_CFG_TOGGLE] = ~c[`UEDB_CFG_TOGGLE];
      end
   endtask
   task automatic conclude();
      if (fail_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Clock, timeout and stimulus.
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         fail_count++;
         conclude();
      end
   end
   initial begin
      logic [2:0] e;
      logic [7:0] v;
      rst = 1'b1;
      we = 1'b0;
      re = 1'b0;
      addr = 7'h00;
      wdata = 8'h00;
      fail_count = 0;
      n_tests = 0;
      for (int i = 0; i < 128; i++) m[i] = 8'h00;
      void'($urandom(32'h727b));
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 16; i++) rd({i[3:0], 3'h0}, 8'h08);
      wr(7'h01, 8'hff);
      rd(7'h01, 8'hff);
      repeat (60) begin
         e = 3'($urandom_range(7, 0));
         for (int o = 0; o < 8; o++) begin
            v = 8'($urandom());
            if (o == 0) v[6] = 1'b0;
            // Counts and size stay within 64; anything larger is undefined.
            if (o == 2 || o == 6) v[6:0] = 7'($urandom_range(64, 0));
            if (o == 7) v = 8'($urandom_range(64, 0));
            if (o != 3 && o != 4) wr({1'b0, e, o[2:0]}, v);
         end
         look(e);
         fin(e, 7'($urandom_range(64, 0)), 0);
         for (int o = 0; o < 8; o++) begin
            if (o != 3 && o != 4) rd({1'b0, e, o[2:0]}, 8'hff);
         end
         look(e);
      end
      // Firmware write in the engine's count cycle: the engine yields once, then completes.
      wr(7'h18, 8'h84);
      wr(7'h19, 8'h20);
      wr(7'h1a, 8'h00);
      wr(7'h1f, 8'h08);
      look(3'h3);
      fork
         fin(3'h3, 7'h2a, 1);
         begin
            @(negedge clk);
            wr(7'h1f, 8'h40);
         end
      join
      rd(7'h1a, 8'hff);
      rd(7'h18, 8'hff);
      rd(7'h1f, 8'hff);
      look(3'h3);
      conclude();
   end
endmodule

// ==== testbench/uedb_mgr_model.sv ====
// Behavioural buffer manager that issues lookups and completions to the descriptor block.
`timescale 1ns/1ps
module uedb_mgr_model (
   input wire logic clk,
   input wire logic ready,
   output logic req,
   output logic [2:0] ep,
   output logic done,
   output logic [2:0] done_ep,
   output logic [6:0] done_len
);
   // ----------------------------------------
   // Request handshake.
   // ----------------------------------------
   initial begin
      req = 1'b0;
      done = 1'b0;
      ep = 3'h0;
      done_ep = 3'h0;
      done_len = 7'h0;
   end
   // Holds the request until an edge that sees READY high, or until 64 cycles pass without READY, then releases it.
   task automatic xfer(input logic is_done, input logic [2:0] e, input logic [6:0] n);
      int k;
      @(negedge clk);
      if (is_done) begin
         done = 1'b1;
         done_ep = e;
         done_len = n;
      end else begin
         req = 1'b1;
         ep = e;
      end
      k = 0;
      while (ready !== 1'b1 && k < 64) begin
         @(negedge clk);
         k++;
      end
      @(posedge clk);
      @(negedge clk);
      req = 1'b0;
      done = 1'b0;
      // Released lines carry the inverse, so a stale value can never pass for a fresh one.
      ep = ~ep;
      done_ep = ~done_ep;
      done_len = ~done_len;
   endtask
endmodule
